// ===== hw/umaf_pkg.sv
package umaf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte offsets on the bus
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [7:0] OFF_BAUD = 8'h0C;

    // status register bit positions
    localparam int ST_RXC  = 0;
    localparam int ST_TXC  = 1;
    localparam int ST_FE   = 2;
    localparam int ST_DBL  = 3;
    localparam int ST_MULTIPROC_FILTER_ENABLE = 4;
    localparam int ST_BUSY = 5;
    localparam int ST_OVR  = 6;

    // control register bit positions
    localparam int CT_RXEN = 0;
    localparam int CT_TXEN = 1;
    localparam int CT_TX_NINTH_BIT = 2;
    localparam int CT_RX_NINTH_BIT = 3;
    localparam int CT_CSZ  = 4;
    localparam int CT_SBS  = 7;

    ////////////////////////////////////////////////////////////////////////////
    localparam int DIV_W = 12;
    localparam logic [2:0]       RST_CSZ  = 3'h3;
    localparam logic [DIV_W-1:0] RST_DIV  = 12'h000;
    localparam logic [2:0]       CSZ_NINE = 3'h7;
    localparam logic [3:0]       CHAR_BASE = 4'h5;
    localparam logic [3:0]       NINE_BITS = 4'h9;

    // oversampling: 16 per bit normal, 8 per bit double speed
    localparam logic [3:0] SMP_LAST_N = 4'hF;
    localparam logic [3:0] SMP_LAST_D = 4'h7;
    // first of three centre samples used for the majority vote
    localparam logic [3:0] SMP_VOTE_N = 4'h7;
    localparam logic [3:0] SMP_VOTE_D = 4'h3;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } umaf_rx_e;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'h1,
        TX_START = 4'h2,
        TX_DATA  = 4'h4,
        TX_STOP  = 4'h8
    } umaf_tx_e;

endpackage

// ===== hw/umaf_baud_gen.sv
`timescale 1ns/10ps
module umaf_baud_gen (
    input  wire logic                       clk,
    input  wire logic                       rstn,
    input  wire logic [umaf_pkg::DIV_W-1:0] divisor,
    output logic                            tick
);

    typedef struct packed {
        logic [umaf_pkg::DIV_W-1:0] cnt;
        logic                       tick;
    } umaf_baud_s;

    umaf_baud_s q;
    umaf_baud_s d;

    // one sample tick every divisor+1 clocks; a new divisor applies at reload
    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (q.cnt == '0) begin
            d.cnt  = divisor;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

    reload_div_a: assert property (@(posedge clk) disable iff (!rstn)
        tick && $stable(divisor) && divisor != '0 |-> q.cnt == divisor ##1 !tick)
        else $error("tick spacing does not follow divisor");

endmodule

// ===== hw/umaf_top.sv
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module umaf_top (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        rxd,
    output logic             txd
);

    typedef struct packed {
        logic                       ack;
        logic [11:0]                rdData;
        logic                       rxEn;
        logic                       txEn;
        logic                       txNinth;
        logic [2:0]                 charSize;
        logic                       stopSel;
        logic                       dblSpd;
        logic                       multiproc_filter_enable;
        logic [umaf_pkg::DIV_W-1:0] divisor;
        logic                       rx_complete_flag;
        logic                       tx_complete_flag;
        logic                       fe;
        logic                       ovr;
        logic [7:0]                 rxData;
        logic                       rxNinth;
        logic [2:0]                 sync;
        logic                       rxLvl;
        umaf_pkg::umaf_rx_e         rxState;
        logic [3:0]                 rxSmp;
        logic [3:0]                 rxBitCnt;
        logic [1:0]                 rxVotes;
        logic [8:0]                 rxShift;
        umaf_pkg::umaf_tx_e         txState;
        logic [3:0]                 txSmp;
        logic [3:0]                 txBitCnt;
        logic [8:0]                 txShift;
        logic                       txd;
    } umaf_state_s;

    umaf_state_s q;
    umaf_state_s d;

    // line idle high, both machines idle, filter off so every frame is taken
    localparam umaf_state_s RST_Q = '{
        charSize: umaf_pkg::RST_CSZ,
        divisor:  umaf_pkg::RST_DIV,
        sync:     3'h7,
        rxLvl:    1'b1,
        rxState:  umaf_pkg::RX_IDLE,
        txState:  umaf_pkg::TX_IDLE,
        txd:      1'b1,
        multiproc_filter_enable:     1'b0,
        default:  '0
    };

    logic       tick;
    logic       acc;
    logic       nine;
    logic [3:0] charBits;
    logic [3:0] smpLast;
    logic [3:0] voteFirst;
    logic       bitDone;
    logic       bitVal;
    logic       frameDone;
    logic       typeBit;
    logic       isAddr;
    logic       keep;
    logic [8:0] aligned;
    logic       txStart;

    umaf_baud_gen u_baud (
        .clk     (clk),
        .rstn    (rstn),
        .divisor (q.divisor),
        .tick    (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // one character size serves both directions
    assign nine     = (q.charSize == umaf_pkg::CSZ_NINE);
    assign charBits = nine ? umaf_pkg::NINE_BITS
                           : umaf_pkg::CHAR_BASE + {2'h0, q.charSize[1:0]};
    assign smpLast   = q.dblSpd ? umaf_pkg::SMP_LAST_D : umaf_pkg::SMP_LAST_N;
    assign voteFirst = q.dblSpd ? umaf_pkg::SMP_VOTE_D : umaf_pkg::SMP_VOTE_N;

    // accepted on the second edge of a request, never earlier
    assign waitrequest = (read || write) && !q.ack;
    assign acc         = (read || write) && q.ack;
    assign txStart     = write && acc && (address == umaf_pkg::OFF_DATA);

    always_comb begin
        d         = q;
        bitDone   = 1'b0;
        bitVal    = 1'b0;
        frameDone = 1'b0;
        typeBit   = 1'b0;
        isAddr    = 1'b0;
        keep      = 1'b0;
        aligned   = q.rxShift >> (4'h9 - charBits);
        d.ack     = (read || write) && !q.ack;

        // read data are caught on the first edge so they stand at the accepting one
        if (read && !q.ack) begin
            if (address == umaf_pkg::OFF_DATA) begin
                d.rdData = {4'h0, q.rxData};
            end else if (address == umaf_pkg::OFF_STAT) begin
                d.rdData                       = 12'h000;
                d.rdData[umaf_pkg::ST_RXC]     = q.rx_complete_flag;
                d.rdData[umaf_pkg::ST_TXC]     = q.tx_complete_flag;
                d.rdData[umaf_pkg::ST_FE]      = q.fe;
                d.rdData[umaf_pkg::ST_DBL]     = q.dblSpd;
                d.rdData[umaf_pkg::ST_MULTIPROC_FILTER_ENABLE]    = q.multiproc_filter_enable;
                d.rdData[umaf_pkg::ST_BUSY]    = (q.txState != umaf_pkg::TX_IDLE);
                d.rdData[umaf_pkg::ST_OVR]     = q.ovr;
            end else if (address == umaf_pkg::OFF_CTRL) begin
                d.rdData                       = 12'h000;
                d.rdData[umaf_pkg::CT_RXEN]    = q.rxEn;
                d.rdData[umaf_pkg::CT_TXEN]    = q.txEn;
                d.rdData[umaf_pkg::CT_TX_NINTH_BIT]    = q.txNinth;
                d.rdData[umaf_pkg::CT_RX_NINTH_BIT]    = q.rxNinth;
                d.rdData[umaf_pkg::CT_CSZ +: 3] = q.charSize;
                d.rdData[umaf_pkg::CT_SBS]     = q.stopSel;
            end else if (address == umaf_pkg::OFF_BAUD) begin
                d.rdData = q.divisor;
            end else begin
                d.rdData = 12'h000;
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // bus writes and clears first, so hardware sets below win
        if (write && acc) begin
            if (address == umaf_pkg::OFF_STAT) begin
                d.dblSpd = writedata[umaf_pkg::ST_DBL];
                d.multiproc_filter_enable   = writedata[umaf_pkg::ST_MULTIPROC_FILTER_ENABLE];
                // writing one to the transmit completion bit clears it as well
                if (writedata[umaf_pkg::ST_TXC]) begin
                    d.tx_complete_flag = 1'b0;
                end
            end else if (address == umaf_pkg::OFF_CTRL) begin
                d.rxEn     = writedata[umaf_pkg::CT_RXEN];
                d.txEn     = writedata[umaf_pkg::CT_TXEN];
                d.txNinth  = writedata[umaf_pkg::CT_TX_NINTH_BIT];
                d.charSize = writedata[umaf_pkg::CT_CSZ +: 3];
                d.stopSel  = writedata[umaf_pkg::CT_SBS];
            end else if (address == umaf_pkg::OFF_BAUD) begin
                d.divisor = writedata[umaf_pkg::DIV_W-1:0];
            end
        end
        if (read && acc && address == umaf_pkg::OFF_DATA) begin
            d.rx_complete_flag = 1'b0;
            d.ovr = 1'b0;
        end

        ////////////////////////////////////////////////////////////////////////
        // pin synchroniser: level moves once stages two and three agree
        d.sync = {q.sync[1:0], rxd};
        if (q.sync[1] == q.sync[2]) begin
            d.rxLvl = q.sync[2];
        end

        if (tick) begin
            if (q.rxState != umaf_pkg::RX_IDLE) begin
                d.rxSmp = q.rxSmp + 4'h1;
                if (q.rxSmp >= voteFirst && q.rxSmp <= voteFirst + 4'h2) begin
                    d.rxVotes = q.rxVotes + {1'b0, q.rxLvl};
                end
                if (q.rxSmp == voteFirst + 4'h2) begin
                    bitDone = 1'b1;
                    bitVal  = (q.rxVotes + {1'b0, q.rxLvl}) >= 2'h2;
                end
                if (q.rxSmp == smpLast) begin
                    d.rxSmp   = 4'h0;
                    d.rxVotes = 2'h0;
                end
            end
            case (q.rxState)
                umaf_pkg::RX_IDLE: begin
                    if (q.rxEn && !q.rxLvl) begin
                        d.rxState = umaf_pkg::RX_START;
                        d.rxSmp   = 4'h1;
                        d.rxVotes = 2'h0;
                    end
                end
                umaf_pkg::RX_START: begin
                    // a high majority in the start bit is a glitch
                    if (bitDone && bitVal) begin
                        d.rxState = umaf_pkg::RX_IDLE;
                        d.rxSmp   = 4'h0;
                    end else if (q.rxSmp == smpLast) begin
                        d.rxState  = umaf_pkg::RX_DATA;
                        d.rxBitCnt = 4'h0;
                    end
                end
                umaf_pkg::RX_DATA: begin
                    if (bitDone) begin
                        d.rxShift = {bitVal, q.rxShift[8:1]};
                    end
                    if (q.rxSmp == smpLast) begin
                        d.rxBitCnt = q.rxBitCnt + 4'h1;
                        if (q.rxBitCnt + 4'h1 == charBits) begin
                            d.rxState = umaf_pkg::RX_STOP;
                        end
                    end
                end
                umaf_pkg::RX_STOP: begin
                    // frame ends at the first stop bit's vote; later stop bits
                    // are idle line and a new start may follow at once
                    if (bitDone) begin
                        frameDone = 1'b1;
                        d.rxState = umaf_pkg::RX_IDLE;
                        d.rxSmp   = 4'h0;
                    end
                end
                default: d.rxState = umaf_pkg::RX_IDLE;
            endcase
        end

        typeBit = nine ? aligned[8] : bitVal;
        isAddr  = typeBit;
        keep    = !q.multiproc_filter_enable || isAddr;
        if (frameDone && keep) begin
            d.rxData  = aligned[7:0];
            d.rxNinth = nine ? aligned[8] : 1'b0;
            d.fe      = !bitVal;
            d.ovr     = q.rx_complete_flag || d.ovr;
            d.rx_complete_flag     = 1'b1;
        end
        // a dropped frame leaves every flag alone

        ////////////////////////////////////////////////////////////////////////
        // transmitter: nothing here looks at the filter bit
        if (txStart && q.txEn && q.txState == umaf_pkg::TX_IDLE) begin
            d.txState  = umaf_pkg::TX_START;
            d.txShift  = {q.txNinth, writedata[7:0]};
            d.txSmp    = 4'h0;
            d.txd      = 1'b0;
        end else if (tick && q.txState != umaf_pkg::TX_IDLE) begin
            d.txSmp = q.txSmp + 4'h1;
            if (q.txSmp == smpLast) begin
                d.txSmp = 4'h0;
                case (q.txState)
                    umaf_pkg::TX_START: begin
                        d.txState  = umaf_pkg::TX_DATA;
                        d.txBitCnt = 4'h0;
                        d.txd      = q.txShift[0];
                    end
                    umaf_pkg::TX_DATA: begin
                        d.txShift  = q.txShift >> 1;
                        d.txBitCnt = q.txBitCnt + 4'h1;
                        d.txd      = q.txShift[1];
                        if (q.txBitCnt + 4'h1 == charBits) begin
                            d.txState  = umaf_pkg::TX_STOP;
                            d.txBitCnt = 4'h0;
                            d.txd      = 1'b1;
                        end
                    end
                    umaf_pkg::TX_STOP: begin
                        // a second stop bit only when selected
                        if (q.stopSel && q.txBitCnt == 4'h0) begin
                            d.txBitCnt = 4'h1;
                        end else begin
                            d.txState = umaf_pkg::TX_IDLE;
                            d.tx_complete_flag     = 1'b1;
                        end
                    end
                    default: begin
                        d.txState = umaf_pkg::TX_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= RST_Q;
        end else begin
            q <= d;
        end
    end

    assign readdata = {20'h0, q.rdData};
    assign txd      = q.txd;

    ////////////////////////////////////////////////////////////////////////////
    // a read of the data register in the same cycle clears flags, so it is left out
    sequence frameEnd_seq;
        frameDone && !(read && acc);
    endsequence

    sequence dataFrame_seq;
        frameEnd_seq ##0 (q.multiproc_filter_enable && !typeBit);
    endsequence

    sequence addrFrame_seq;
        frameDone ##0 typeBit;
    endsequence

    sequence busReq_seq;
        (read || write) && waitrequest;
    endsequence

    drop_data_a: assert property (@(posedge clk) disable iff (!rstn)
        dataFrame_seq |=> $stable(q.rx_complete_flag) && $stable(q.rxData) && $stable(q.fe))
        else $error("filtered data frame changed receive state");

    keep_addr_a: assert property (@(posedge clk) disable iff (!rstn)
        addrFrame_seq |=> q.rx_complete_flag)
        else $error("address frame did not set receive complete");

    open_data_a: assert property (@(posedge clk) disable iff (!rstn)
        frameEnd_seq ##0 !q.multiproc_filter_enable |=> q.rx_complete_flag)
        else $error("frame lost with filter off");

    ninth_bit_a: assert property (@(posedge clk) disable iff (!rstn)
        addrFrame_seq ##0 nine |=> q.rxNinth)
        else $error("ninth bit not shown for address frame");

    smp_range_a: assert property (@(posedge clk) disable iff (!rstn)
        q.rxState != umaf_pkg::RX_IDLE |-> q.rxSmp <= smpLast)
        else $error("sample counter beyond bit length");

    bus_ack_a: assert property (@(posedge clk) disable iff (!rstn)
        busReq_seq |=> !waitrequest)
        else $error("request not accepted on second edge");

endmodule

// ===== test/umaf_serial_peer.sv
`timescale 1ns/10ps
module umaf_serial_peer (
    input  wire logic        clk,
    input  wire logic        txd,
    input  wire logic [15:0] bitCyc,
    input  wire logic [3:0]  txBits,
    output logic             rxd,
    output logic [8:0]       txFrame,
    output logic             txDone
);
    // idle line sits high between frames
    initial begin
        rxd = 1'b1;
        txFrame = 9'h000;
        txDone = 1'b0;
    end

    task automatic hold_bit(input logic b);
        rxd <= b;
        repeat (bitCyc) @(posedge clk);
    endtask

    // type bit lands in the ninth bit or the first stop bit; one more high stop bit always follows it
    task automatic send(input logic [8:0] d, input logic [3:0] nb, input logic typeBit);
        hold_bit(1'b0);
        for (int i = 0; i < 8; i++) begin
            if (i < nb) hold_bit(d[i]);
        end
        hold_bit(typeBit);
        hold_bit(1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // samples each transmitted bit at its centre
    always begin
        @(negedge txd);
        repeat (bitCyc / 2) @(posedge clk);
        for (int i = 0; i < txBits; i++) begin
            repeat (bitCyc) @(posedge clk);
            txFrame[i] <= txd;
        end
        txDone <= 1'b1;
        @(posedge clk);
        txDone <= 1'b0;
    end
endmodule

// ===== test/umaf_top_test.sv
`timescale 1ns/10ps
module umaf_top_test;
    localparam logic [11:0] DIV = 12'h003;
    localparam logic [31:0] SM  = 32'h15;
    logic        clk, rstn, read, write, rxd, txd, waitrequest, rdSeen, txDone;
    logic [7:0]  address;
    logic [31:0] writedata, readdata, rdCap;
    logic [15:0] bitCyc;
    logic [3:0]  txBits;
    logic [8:0]  txFrame, d;
    logic [31:0] expQ[$], mskQ[$];
    logic [8:0]  txQ[$];
    int          errors, nCompared, n;

    umaf_top u_dut (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .rxd(rxd), .txd(txd));
    umaf_serial_peer u_peer (.clk(clk), .txd(txd), .bitCyc(bitCyc), .txBits(txBits), .rxd(rxd),
        .txFrame(txFrame), .txDone(txDone));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("compared %0d mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp_reg(input logic [31:0] e, input logic [31:0] g);
        nCompared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] readdata expected %h seen %h", e, g);
        end
    endtask

    task automatic cmp_tx(input logic [8:0] e, input logic [8:0] g);
        nCompared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] txFrame expected %h seen %h", e, g);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        int k;
        k = 0;
        address <= a;
        read <= ~wr;
        write <= wr;
        writedata <= wd;
        do begin
            @(posedge clk);
            k++;
        end while (waitrequest !== 1'b0 && k < 500);
        rdCap <= readdata;
        rdSeen <= ~wr;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            errors++;
            complete_run();
        end
        @(posedge clk);
        rdSeen <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back(e & m);
        mskQ.push_back(m);
        bus(a, 1'b0, 32'h0);
    endtask

    function automatic logic [31:0] st(input logic rx_complete_flag, input logic mp);
        return (32'(rx_complete_flag) << umaf_pkg::ST_RXC) | (32'(mp) << umaf_pkg::ST_MULTIPROC_FILTER_ENABLE);
    endfunction

    // two stop bits whenever the stop bit carries the frame type
    function automatic logic [31:0] ctl(input logic [2:0] csz, input logic tb8);
        return 32'h3 | (32'(tb8) << umaf_pkg::CT_TX_NINTH_BIT) | (32'(csz) << umaf_pkg::CT_CSZ)
            | (32'(csz != umaf_pkg::CSZ_NINE) << umaf_pkg::CT_SBS);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // second process: pairs each observed result with the oldest note
    always @(posedge clk) begin
        if (rdSeen === 1'b1) begin
            if (mskQ[0] != 32'h0) cmp_reg(expQ[0], rdCap & mskQ[0]);
            void'(expQ.pop_front());
            void'(mskQ.pop_front());
        end
        if (txDone === 1'b1) cmp_tx(txQ.pop_front(), txFrame);
    end

    task automatic frame_case(input logic [2:0] csz);
        logic [3:0]  nb;
        logic [31:0] dm;
        nb = (csz == umaf_pkg::CSZ_NINE) ? umaf_pkg::NINE_BITS : umaf_pkg::CHAR_BASE + 4'(csz);
        dm = (nb > 4'h8) ? 32'hFF : (32'h1 << nb) - 32'h1;
        d = 9'($urandom);
        bus(umaf_pkg::OFF_CTRL, 1'b1, ctl(csz, 1'b0));
        bus(umaf_pkg::OFF_STAT, 1'b1, st(1'b0, 1'b1));
        rd(umaf_pkg::OFF_STAT, st(1'b0, 1'b1), SM);
        u_peer.send(~d, nb, 1'b0);
        rd(umaf_pkg::OFF_STAT, st(1'b0, 1'b1), SM);
        u_peer.send(d, nb, 1'b1);
        rd(umaf_pkg::OFF_STAT, st(1'b1, 1'b1), SM);
        rd(umaf_pkg::OFF_CTRL, (nb > 4'h8) ? 32'h8 : 32'h0, 32'h8);
        rd(umaf_pkg::OFF_DATA, 32'(d), dm);
    endtask

    initial begin
        rstn = 1'b0;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        rdSeen = 1'b0;
        rdCap = 32'h0;
        bitCyc = 16'(16 * (DIV + 1));
        txBits = 4'h9;
        errors = 0;
        nCompared = 0;
        void'($urandom(32'h1621));
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rd(umaf_pkg::OFF_STAT, 32'h0, SM);
        rd(umaf_pkg::OFF_CTRL, 32'(umaf_pkg::RST_CSZ) << umaf_pkg::CT_CSZ, 32'h70);
        rd(8'h10, 32'h0, 32'hFFFFFFFF);
        bus(umaf_pkg::OFF_BAUD, 1'b1, 32'(DIV));
        for (int c = 0; c < 4; c++) frame_case(3'(c));
        frame_case(umaf_pkg::CSZ_NINE);
        bus(umaf_pkg::OFF_STAT, 1'b1, 32'h0);
        d = 9'($urandom);
        u_peer.send(d, 4'h9, 1'b0);
        rd(umaf_pkg::OFF_STAT, st(1'b1, 1'b0), SM);
        rd(umaf_pkg::OFF_CTRL, 32'h0, 32'h8);
        rd(umaf_pkg::OFF_DATA, 32'(d), 32'hFF);
        // double speed halves the samples per bit, so the bit time halves too
        bus(umaf_pkg::OFF_STAT, 1'b1, st(1'b0, 1'b1) | 32'h8);
        bitCyc <= 16'(8 * (DIV + 1));
        @(posedge clk);
        u_peer.send(9'h0A5, 4'h9, 1'b1);
        rd(umaf_pkg::OFF_STAT, st(1'b1, 1'b1), SM);
        rd(umaf_pkg::OFF_DATA, 32'hA5, 32'hFF);
        // transmit with the filter still set
        bus(umaf_pkg::OFF_CTRL, 1'b1, ctl(umaf_pkg::CSZ_NINE, 1'b1));
        d = 9'($urandom);
        txQ.push_back({1'b1, d[7:0]});
        bus(umaf_pkg::OFF_DATA, 1'b1, 32'(d[7:0]));
        for (n = 0; n < 4000 && txDone !== 1'b1; n++) @(posedge clk);
        if (n >= 4000) errors++;
        repeat (3) @(posedge clk);
        complete_run();
    end
endmodule
